// ---- logic/acs_calibration_sequencer.sv ----
// acs_calibration_sequencer: foreground/background calibration control of three converter cores
// assumes a 25 MHz clock, synchronous reset and a strobe register port
// Overview of operation
// - background mode calibrates the spare, swaps it in, then calibrates the removed core
// - with low-power background on, off-line cores stay powered down until woken for calibration
// - low-power, automatic swapping: spare sleeps for the programmed sleep delay
// - a woken core waits the programmed wake delay before calibration
// - manual swap select makes low-power wake-up wait for the chosen trigger
// - foreground offset enable runs input offset calibration once per foreground run
// - background offset enable repeats offset calibration on every background pass
// - offset calibration owns the trim register; software writes are dropped while either offset enable bit is set
// - foreground calibration takes cores offline and outputs mid-code
// - foreground starts on pin or software trigger, chosen by the pin select bit
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module acs_calibration_sequencer #(
  parameter int CAL_CYCLES = acs_pkg::CORE_CAL_CYCLES,
  parameter int AVG_LOG2 = acs_pkg::OFFSET_AVG_LOG2
) (
  input logic clk,
  input logic reset,
  input logic [acs_pkg::ADDR_W-1:0] reg_addr,
  input logic [acs_pkg::DATA_W-1:0] reg_wdata,
  input logic reg_write,
  input logic reg_read,
  output logic [acs_pkg::DATA_W-1:0] reg_rdata,
  input logic calibration_trigger_pin,
  input logic [acs_pkg::SAMPLE_W-1:0] sample_in,
  output logic [acs_pkg::SAMPLE_W-1:0] sample_out,
  output logic [2:0] core_online,
  output logic [2:0] core_powered,
  output logic [2:0] core_cal_active,
  output logic [1:0] spare_core,
  output logic [acs_pkg::SAMPLE_W-1:0] input_offset_trim,
  output logic fg_cal_busy,
  output logic irq
);
  import acs_pkg::*;

  localparam logic [DLY_W-1:0] CAL_LEN = DLY_W'(CAL_CYCLES);

  // ********************
  // state
  // ********************
  typedef struct packed {
    acs_state_t state;
    logic [CTRL_W-1:0] ctrl;
    logic soft_trig;
    logic soft_prev;
    logic [DLY_W-1:0] sleep_dly;
    logic [DLY_W-1:0] wake_dly;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [SAMPLE_W-1:0] trim;
    logic foreground_complete_flag;
    logic [1:0] spare;
    logic [1:0] slot0;
    logic [1:0] slot1;
    logic victim;
    logic [2:0] powered;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic tmr_start;
    logic [DLY_W-1:0] tmr_len;
    logic ofs_start;
    logic [DATA_W-1:0] rdata;
    logic [SAMPLE_W-1:0] sample_out;
  } acs_top_t;

  localparam acs_top_t TOP_RST = '{
    state: S_FG_CAL, ctrl: CTRL_RST, soft_trig: 1'b0, soft_prev: 1'b0,
    sleep_dly: SLEEP_DLY_RST, wake_dly: WAKE_DLY_RST, irq_status: '0, irq_enable: '0,
    trim: TRIM_RST, foreground_complete_flag: 1'b0, spare: 2'h2, slot0: 2'h0, slot1: 2'h1, victim: 1'b0,
    powered: 3'h3, pin_s1: 1'b0, pin_s2: 1'b0, pin_s3: 1'b0, tmr_start: 1'b1,
    tmr_len: CAL_LEN, ofs_start: 1'b0, rdata: '0, sample_out: MID_CODE
  };

  acs_top_t r_reg, r_next;

  acs_step_if #(.W(DLY_W)) tmr_if ();
  acs_step_if #(.W(DLY_W)) ofs_if ();

  // ********************
  // step engines
  // ********************
  assign tmr_if.start = r_reg.tmr_start;
  assign tmr_if.length = r_reg.tmr_len;
  assign ofs_if.start = r_reg.ofs_start;
  assign ofs_if.length = '0;

  acs_step_timer u_timer (
    .clk(clk),
    .reset(reset),
    .st(tmr_if.step)
  );

  acs_offset_engine #(.AVG_LOG2(AVG_LOG2)) u_offset (
    .clk(clk),
    .reset(reset),
    .sample_in(sample_in),
    .st(ofs_if.step)
  );

  // ********************
  // decoded controls
  // ********************
  logic bg_on;
  logic ofs_in_use;
  logic trig_evt;
  logic fg_state;
  assign bg_on = r_reg.ctrl[C_BG_EN] & r_reg.ctrl[C_CAL_EN];
  assign ofs_in_use = r_reg.ctrl[C_FG_OS] | r_reg.ctrl[C_BG_OS];
  // trigger source chosen by pin select; pin edge read after the second sync stage
  assign trig_evt = r_reg.ctrl[C_PIN_SEL] ? (r_reg.pin_s2 & ~r_reg.pin_s3)
                                          : (r_reg.soft_trig & ~r_reg.soft_prev);
  assign fg_state = (r_reg.state == S_FG_CAL) || (r_reg.state == S_FG_OFS);

  // ********************
  // next state
  // ********************
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic do_swap;
    logic enter_bg;
    ev = '0;
    clr = '0;
    do_swap = 1'b0;
    enter_bg = 1'b0;
    r_next = r_reg;
    r_next.pin_s1 = calibration_trigger_pin;
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.pin_s3 = r_reg.pin_s2;
    r_next.soft_prev = r_reg.soft_trig;
    r_next.tmr_start = 1'b0;
    r_next.ofs_start = 1'b0;

    // register writes
    if (reg_write) begin
      case (reg_addr)
        A_CTRL: r_next.ctrl = reg_wdata[CTRL_W-1:0];
        A_SOFT_TRIG: r_next.soft_trig = reg_wdata[0];
        A_SLEEP_DLY: r_next.sleep_dly = reg_wdata[DLY_W-1:0];
        A_WAKE_DLY: r_next.wake_dly = reg_wdata[DLY_W-1:0];
        A_IRQ_CLEAR: clr = reg_wdata[IRQ_W-1:0];
        A_IRQ_ENABLE: r_next.irq_enable = reg_wdata[IRQ_W-1:0];
        A_OFFSET_TRIM: begin
          if (!ofs_in_use) begin
            r_next.trim = reg_wdata[SAMPLE_W-1:0];
          end
        end
        default: ;
      endcase
    end

    // sequencer
    case (r_reg.state)
      S_IDLE: begin
        if (bg_on) begin
          enter_bg = 1'b1;
        end else if (r_reg.ctrl[C_CAL_EN] && trig_evt) begin
          r_next.state = S_FG_CAL;
          r_next.foreground_complete_flag = 1'b0;
          r_next.tmr_start = 1'b1;
          r_next.tmr_len = CAL_LEN;
        end
      end
      S_FG_CAL: begin
        if (tmr_if.done) begin
          if (r_reg.ctrl[C_FG_OS]) begin
            r_next.state = S_FG_OFS;
            r_next.ofs_start = 1'b1;
          end else begin
            r_next.state = S_IDLE;
            r_next.foreground_complete_flag = 1'b1;
            ev[I_FOREGROUND_COMPLETE_FLAG] = 1'b1;
          end
        end
      end
      S_FG_OFS: begin
        if (ofs_if.done) begin
          r_next.trim = ofs_if.result;
          r_next.state = S_IDLE;
          r_next.foreground_complete_flag = 1'b1;
          ev[I_FOREGROUND_COMPLETE_FLAG] = 1'b1;
          ev[I_OFFSET] = 1'b1;
        end
      end
      S_BG_SLEEP: begin
        if (!bg_on) begin
          r_next.state = S_IDLE;
        end else if (r_reg.ctrl[C_MANUAL] ? trig_evt : tmr_if.done) begin
          r_next.state = S_BG_WAKE;
          r_next.powered = r_reg.powered | acs_onehot(r_reg.spare);
          r_next.tmr_start = 1'b1;
          r_next.tmr_len = r_reg.wake_dly;
        end
      end
      S_BG_WAKE: begin
        if (tmr_if.done) begin
          r_next.state = S_BG_CAL;
          r_next.tmr_start = 1'b1;
          r_next.tmr_len = CAL_LEN;
        end
      end
      S_BG_CAL: begin
        if (tmr_if.done) begin
          if (r_reg.ctrl[C_BG_OS]) begin
            r_next.state = S_BG_OFS;
            r_next.ofs_start = 1'b1;
          end else begin
            do_swap = 1'b1;
          end
        end
      end
      S_BG_OFS: begin
        if (ofs_if.done) begin
          r_next.trim = ofs_if.result;
          ev[I_OFFSET] = 1'b1;
          do_swap = 1'b1;
        end
      end
      default: r_next.state = S_IDLE;
    endcase

    // calibrated spare takes the place of the next active core in turn
    if (do_swap) begin
      if (r_reg.victim) begin
        r_next.slot1 = r_reg.spare;
        r_next.spare = r_reg.slot1;
      end else begin
        r_next.slot0 = r_reg.spare;
        r_next.spare = r_reg.slot0;
      end
      r_next.victim = ~r_reg.victim;
      ev[I_SWAP] = 1'b1;
      enter_bg = 1'b1;
    end

    // start the next background pass, or drop back to idle
    if (enter_bg) begin
      if (!bg_on) begin
        r_next.state = S_IDLE;
        r_next.powered = acs_onehot(r_next.slot0) | acs_onehot(r_next.slot1);
      end else if (r_reg.ctrl[C_LOW_POWER_BG_ENABLE]) begin
        r_next.state = S_BG_SLEEP;
        r_next.powered = acs_onehot(r_next.slot0) | acs_onehot(r_next.slot1);
        r_next.tmr_start = ~r_reg.ctrl[C_MANUAL];
        r_next.tmr_len = r_reg.sleep_dly;
      end else begin
        r_next.state = S_BG_CAL;
        r_next.powered = 3'h7;
        r_next.tmr_start = 1'b1;
        r_next.tmr_len = CAL_LEN;
      end
    end

    // sticky events, a new event wins over its clear
    r_next.irq_status = (r_reg.irq_status & ~clr) | ev;

    // read data stands one cycle after the read strobe
    r_next.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        A_CTRL: r_next.rdata = DATA_W'(r_reg.ctrl);
        A_SOFT_TRIG: r_next.rdata = DATA_W'(r_reg.soft_trig);
        A_SLEEP_DLY: r_next.rdata = DATA_W'(r_reg.sleep_dly);
        A_WAKE_DLY: r_next.rdata = DATA_W'(r_reg.wake_dly);
        A_STATUS: r_next.rdata = DATA_W'({r_reg.powered, core_online, r_reg.spare,
                                          (r_reg.state != S_IDLE) && !fg_state, fg_state, r_reg.foreground_complete_flag});
        A_IRQ_STATUS: r_next.rdata = DATA_W'(r_reg.irq_status);
        A_IRQ_ENABLE: r_next.rdata = DATA_W'(r_reg.irq_enable);
        A_OFFSET_TRIM: r_next.rdata = DATA_W'(r_reg.trim);
        default: r_next.rdata = '0;
      endcase
    end

    // output data held at mid-code during foreground calibration
    r_next.sample_out = fg_state ? MID_CODE : sample_in;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= TOP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ********************
  // outputs
  // ********************
  assign reg_rdata = r_reg.rdata;
  assign sample_out = r_reg.sample_out;
  assign core_online = fg_state ? 3'h0 : (acs_onehot(r_reg.slot0) | acs_onehot(r_reg.slot1));
  assign core_powered = r_reg.powered;
  assign core_cal_active = fg_state ? (acs_onehot(r_reg.slot0) | acs_onehot(r_reg.slot1)) :
                           ((r_reg.state == S_BG_CAL) || (r_reg.state == S_BG_OFS)) ? acs_onehot(r_reg.spare) : 3'h0;
  assign spare_core = r_reg.spare;
  assign input_offset_trim = r_reg.trim;
  assign fg_cal_busy = fg_state;
  assign irq = |(r_reg.irq_status & r_reg.irq_enable);

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_fg_mid_code: assert property (fg_state |-> core_online == 3'h0 ##1 sample_out == MID_CODE)
    else $error("sample not at mid-code during foreground calibration");
  a_trig_start: assert property (r_reg.state == S_IDLE && !bg_on && r_reg.ctrl[C_CAL_EN] && trig_evt
    |=> r_reg.state == S_FG_CAL && !r_reg.foreground_complete_flag)
    else $error("trigger did not start foreground calibration");
  a_done_clear: assert property (r_reg.state == S_FG_CAL |-> !r_reg.foreground_complete_flag)
    else $error("done flag set while foreground calibration runs");
  a_fg_offset_once: assert property (r_reg.state == S_FG_CAL && tmr_if.done && r_reg.ctrl[C_FG_OS]
    |=> r_reg.state == S_FG_OFS ##1 r_reg.state == S_FG_OFS)
    else $error("foreground offset step skipped");
  a_foreground_complete_flag_set: assert property (r_reg.state == S_FG_OFS && ofs_if.done |=> r_reg.foreground_complete_flag && r_reg.state == S_IDLE)
    else $error("done flag not set after foreground offset step");
  a_bg_offset: assert property (r_reg.state == S_BG_CAL && tmr_if.done && r_reg.ctrl[C_BG_OS]
    |=> r_reg.state == S_BG_OFS)
    else $error("background offset step skipped");
  a_trim_locked: assert property (reg_write && reg_addr == A_OFFSET_TRIM && ofs_in_use && !ofs_if.done
    |=> $stable(input_offset_trim))
    else $error("trim written while offset calibration in use");
  a_lp_sleep_off: assert property (r_reg.state == S_BG_SLEEP |-> !core_powered[r_reg.spare])
    else $error("sleeping spare core is powered");
  a_wake_powered: assert property (r_reg.state == S_BG_WAKE |-> core_powered[r_reg.spare] && core_cal_active == 3'h0)
    else $error("woken core not powered or calibrating early");
  a_manual_hold: assert property (r_reg.state == S_BG_SLEEP && bg_on && r_reg.ctrl[C_MANUAL] && !trig_evt
    |=> r_reg.state == S_BG_SLEEP)
    else $error("manual mode woke without trigger");
  a_two_online: assert property (!fg_state |-> $countones(core_online) == 2 && !core_online[r_reg.spare])
    else $error("active core count wrong outside foreground");

  c_foreground_complete_flag: cover property (r_reg.state == S_FG_OFS && ofs_if.done);
  c_bg_swap: cover property (r_reg.state == S_BG_CAL ##1 r_reg.state == S_BG_SLEEP);
  c_bg_offset: cover property (r_reg.state == S_BG_OFS && ofs_if.done);
  c_manual_wake: cover property (r_reg.state == S_BG_SLEEP && r_reg.ctrl[C_MANUAL] ##1 r_reg.state == S_BG_WAKE);
endmodule : acs_calibration_sequencer

// ---- logic/acs_pkg.sv ----
// acs_pkg: constants, register map and types of the calibration sequencer
// assumes one 25 MHz clock and a plain strobe register port
package acs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SAMPLE_W = 12;
  localparam int DLY_W = 16;
  localparam int CTRL_W = 7;
  localparam int IRQ_W = 3;

  // ********************
  // register offsets
  // ********************
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_SOFT_TRIG = 8'h04;
  localparam logic [ADDR_W-1:0] A_SLEEP_DLY = 8'h08;
  localparam logic [ADDR_W-1:0] A_WAKE_DLY = 8'h0c;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] A_IRQ_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] A_IRQ_CLEAR = 8'h18;
  localparam logic [ADDR_W-1:0] A_IRQ_ENABLE = 8'h1c;
  localparam logic [ADDR_W-1:0] A_OFFSET_TRIM = 8'h20;

  // ********************
  // control bit positions
  // ********************
  localparam int C_BG_EN = 0;      // background_cal_enable
  localparam int C_PIN_SEL = 1;    // pin_trigger_select
  localparam int C_LOW_POWER_BG_ENABLE = 2;      // low_power_bg_enable
  localparam int C_MANUAL = 3;     // manual_swap_select
  localparam int C_FG_OS = 4;      // fg_offset_cal_enable
  localparam int C_BG_OS = 5;      // bg_offset_cal_enable
  localparam int C_CAL_EN = 6;     // calibration enable

  // interrupt bit positions
  localparam int I_FOREGROUND_COMPLETE_FLAG = 0;
  localparam int I_SWAP = 1;
  localparam int I_OFFSET = 2;

  // ********************
  // reset values
  // ********************
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [DLY_W-1:0] SLEEP_DLY_RST = 16'h0100;
  localparam logic [DLY_W-1:0] WAKE_DLY_RST = 16'h0040;
  localparam logic [SAMPLE_W-1:0] TRIM_RST = 12'h000;
  localparam logic [SAMPLE_W-1:0] MID_CODE = 12'h000;

  // ********************
  // timing
  // ********************
  localparam int CLK_PERIOD_NS = 40;
  localparam int CORE_CAL_TIME_NS = 40000;
  localparam int CORE_CAL_CYCLES = (CORE_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFFSET_AVG_LOG2 = 6;

  typedef enum logic [2:0] {
    S_IDLE, S_FG_CAL, S_FG_OFS, S_BG_SLEEP, S_BG_WAKE, S_BG_CAL, S_BG_OFS
  } acs_state_t;

  // one-hot mask of a core index 0..2
  function automatic logic [2:0] acs_onehot(input logic [1:0] idx);
    acs_onehot = 3'h1 << idx;
  endfunction : acs_onehot
endpackage : acs_pkg

// ---- logic/acs_step_if.sv ----
// acs_step_if: start/done handshake of one calibration step
// assumes both ends share clk
`timescale 1ns/1ns
interface acs_step_if #(parameter int W = 16);
  logic start;
  logic [W-1:0] length;
  logic done;
  logic signed [11:0] result;
  modport ctrl (output start, output length, input done, input result);
  modport step (input start, input length, output done, output result);
endinterface : acs_step_if

// ---- logic/acs_step_timer.sv ----
// acs_step_timer: counts a loaded number of cycles, then one done pulse
// assumes start is a one-cycle pulse; a new start restarts the count
`timescale 1ns/1ns
module acs_step_timer (
  input logic clk,
  input logic reset,
  acs_step_if.step st
);
  import acs_pkg::*;
  typedef struct packed {
    logic busy;
    logic done;
    logic [DLY_W-1:0] cnt;
  } acs_tmr_t;
  acs_tmr_t r_reg, r_next;

  // load, count down, pulse done on the last cycle
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (st.start) begin
      r_next.busy = 1'b1;
      r_next.cnt = (st.length == '0) ? DLY_W'(1) : st.length;
    end else if (r_reg.busy) begin
      if (r_reg.cnt == DLY_W'(1)) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt - DLY_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign st.done = r_reg.done;
  assign st.result = '0;
endmodule : acs_step_timer

// ---- logic/acs_offset_engine.sv ----
// acs_offset_engine: averages input samples and yields the offset trim
// assumes input is muted near DC while it runs
`timescale 1ns/1ns
module acs_offset_engine #(
  parameter int AVG_LOG2 = 6
) (
  input logic clk,
  input logic reset,
  input logic [acs_pkg::SAMPLE_W-1:0] sample_in,
  acs_step_if.step st
);
  import acs_pkg::*;
  localparam int ACC_W = SAMPLE_W + AVG_LOG2;
  typedef struct packed {
    logic busy;
    logic done;
    logic [AVG_LOG2:0] cnt;
    logic signed [ACC_W-1:0] acc;
    logic signed [SAMPLE_W-1:0] trim;
  } acs_ofs_t;
  acs_ofs_t r_reg, r_next;

  // accumulate 2^AVG_LOG2 samples, trim is the negated mean
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (st.start) begin
      r_next.busy = 1'b1;
      r_next.cnt = '0;
      r_next.acc = '0;
    end else if (r_reg.busy) begin
      r_next.acc = r_reg.acc + ACC_W'(signed'(sample_in));
      r_next.cnt = r_reg.cnt + 1'b1;
      if (r_reg.cnt == (AVG_LOG2 + 1)'((1 << AVG_LOG2) - 1)) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
        r_next.trim = -SAMPLE_W'(r_next.acc >>> AVG_LOG2);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign st.done = r_reg.done;
  assign st.result = r_reg.trim;
endmodule : acs_offset_engine

// ---- tb/acs_calibration_sequencer_tb.sv ----
// acs_calibration_sequencer_tb: register-level tests of the calibration sequencer
// assumes acs_pkg, a 25 MHz clock and shortened calibration counts
`timescale 1ns/1ns
module acs_calibration_sequencer_tb;
  import acs_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic calibration_trigger_pin = 1'b0;
  logic [SAMPLE_W-1:0] sample_in = 12'h004;
  logic [SAMPLE_W-1:0] sample_out;
  logic [SAMPLE_W-1:0] input_offset_trim;
  logic [2:0] core_online;
  logic [2:0] core_powered;
  logic [2:0] core_cal_active;
  logic [1:0] spare_core;
  logic [1:0] sp;
  logic fg_cal_busy;
  logic irq;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  int bad;

  // 40 ns clock
  always #20 clk = ~clk;

  acs_calibration_sequencer #(.CAL_CYCLES(20), .AVG_LOG2(2)) acs_calibration_sequencer_inst (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .calibration_trigger_pin(calibration_trigger_pin), .sample_in(sample_in),
    .sample_out(sample_out), .core_online(core_online), .core_powered(core_powered),
    .core_cal_active(core_cal_active), .spare_core(spare_core),
    .input_offset_trim(input_offset_trim), .fg_cal_busy(fg_cal_busy), .irq(irq));

  // ********************
  // tasks
  // ********************
  task automatic chk32(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic chk12(input string what, input logic [SAMPLE_W-1:0] exp, input logic [SAMPLE_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk12

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  // read data stand in the cycle after the strobe edge
  task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
                      input logic [DATA_W-1:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk32(what, exp, reg_rdata & m);
  endtask : rchk

  // let one edge pass so the trigger event has been taken before anyone polls
  task automatic soft_trig();
    wr(A_SOFT_TRIG, 32'h0);
    wr(A_SOFT_TRIG, 32'h1);
    @(posedge clk);
    #1;
  endtask : soft_trig

  // pin pulse, then wait a bounded time for foreground to start
  task automatic pin_pulse();
    @(posedge clk);
    calibration_trigger_pin <= 1'b1;
    repeat (2) @(posedge clk);
    calibration_trigger_pin <= 1'b0;
    for (int k = 0; k < 10 && fg_cal_busy !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask : pin_pulse

  task automatic wait_idle();
    for (int k = 0; k < 400 && fg_cal_busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    chk12("fg_cal_busy", 12'h000, {11'h0, fg_cal_busy});
  endtask : wait_idle

  // waits for the spare to change, counting cycles with output interrupted
  task automatic wait_swap();
    sp = spare_core;
    bad = 0;
    for (int k = 0; k < 400 && spare_core === sp; k++) begin
      @(posedge clk);
      #1;
      if (fg_cal_busy !== 1'b0 || core_online === 3'h0 || sample_out !== sample_in) bad++;
    end
    chk12("spare moved", 12'h001, {11'h0, spare_core !== sp});
    chk12("interrupted cycles", 12'h000, 12'(bad));
  endtask : wait_swap

  task automatic test_done();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // ********************
  // tests
  // ********************
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    // power-up foreground run mutes data
    chk12("sample_out", 12'h000, sample_out);
    chk12("core_online", 12'h000, {9'h0, core_online});
    chk12("core_powered", 12'h003, {9'h0, core_powered});
    wait_idle();
    // muted output lags the state by one cycle
    @(posedge clk);
    #1;
    chk12("sample_out", 12'h004, sample_out);
    rchk("status", A_STATUS, 32'h7, 32'h1);
    rchk("ctrl", A_CTRL, 32'hffffffff, 32'h0);
    rchk("sleep", A_SLEEP_DLY, 32'hffffffff, 32'h100);
    rchk("wake", A_WAKE_DLY, 32'hffffffff, 32'h40);
    rchk("unmapped", 8'h24, 32'hffffffff, 32'h0);
    // interrupt raise, mask, clear
    rchk("irq_status", A_IRQ_STATUS, 32'h1, 32'h1);
    chk12("irq", 12'h000, {11'h0, irq});
    wr(A_IRQ_ENABLE, 32'h1);
    chk12("irq", 12'h001, {11'h0, irq});
    wr(A_IRQ_ENABLE, 32'h0);
    chk12("irq", 12'h000, {11'h0, irq});
    wr(A_IRQ_CLEAR, 32'h7);
    wr(A_IRQ_ENABLE, 32'h7);
    rchk("irq_status", A_IRQ_STATUS, 32'h7, 32'h0);
    chk12("irq", 12'h000, {11'h0, irq});
    // pin ignored while software trigger is selected
    wr(A_CTRL, 32'h40);
    pin_pulse();
    chk12("fg_cal_busy", 12'h000, {11'h0, fg_cal_busy});
    // pin selected starts foreground
    wr(A_CTRL, 32'h42);
    pin_pulse();
    chk12("fg_cal_busy", 12'h001, {11'h0, fg_cal_busy});
    rchk("status", A_STATUS, 32'h3, 32'h2);
    chk12("sample_out", 12'h000, sample_out);
    wait_idle();
    rchk("status", A_STATUS, 32'h3, 32'h1);
    chk12("irq", 12'h001, {11'h0, irq});
    // one-time offset step by software trigger
    wr(A_IRQ_CLEAR, 32'h7);
    wr(A_CTRL, 32'h10);
    wr(A_CTRL, 32'h50);
    soft_trig();
    wait_idle();
    rchk("status", A_STATUS, 32'h1, 32'h1);
    rchk("trim", A_OFFSET_TRIM, 32'hfff, 32'hffc);
    chk12("trim port", 12'hffc, input_offset_trim);
    rchk("irq_status", A_IRQ_STATUS, 32'h5, 32'h5);
    @(posedge clk);
    sample_in <= 12'h008;
    repeat (60) @(posedge clk);
    rchk("trim", A_OFFSET_TRIM, 32'hfff, 32'hffc);
    wr(A_OFFSET_TRIM, 32'h055);
    rchk("trim", A_OFFSET_TRIM, 32'hfff, 32'hffc);
    wr(A_CTRL, 32'h0);
    wr(A_OFFSET_TRIM, 32'h055);
    rchk("trim", A_OFFSET_TRIM, 32'hfff, 32'h055);
    // background with repeated offset correction
    wr(A_IRQ_CLEAR, 32'h7);
    wr(A_CTRL, 32'h61);
    soft_trig();
    wait_swap();
    chk12("spare offline", 12'h000, {11'h0, core_online[spare_core]});
    rchk("irq_status", A_IRQ_STATUS, 32'h2, 32'h2);
    chk12("trim port", 12'hff8, input_offset_trim);
    @(posedge clk);
    sample_in <= 12'h010;
    wait_swap();
    wait_swap();
    chk12("trim port", 12'hff0, input_offset_trim);
    // low-power automatic: sleep, then wake delay
    wr(A_SLEEP_DLY, 32'd40);
    wr(A_WAKE_DLY, 32'd12);
    wr(A_CTRL, 32'h45);
    wait_swap();
    wait_swap();
    chk12("spare powered", 12'h000, {11'h0, core_powered[spare_core]});
    for (n = 0; n < 200 && core_powered[spare_core] !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk12("sleep span ok", 12'h001, {11'h0, n >= 36 && n <= 46});
    for (n = 0; n < 200 && core_cal_active[spare_core] !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk12("wake span ok", 12'h001, {11'h0, n >= 10 && n <= 16});
    // low-power manual: spare sleeps until the trigger
    wr(A_CTRL, 32'h4d);
    wait_swap();
    repeat (150) @(posedge clk);
    #1;
    chk12("spare powered", 12'h000, {11'h0, core_powered[spare_core]});
    soft_trig();
    for (n = 0; n < 20 && core_powered[spare_core] !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk12("spare powered", 12'h001, {11'h0, core_powered[spare_core]});
    test_done();
  end
endmodule : acs_calibration_sequencer_tb
